//--- rtl/command_fifo_status_regs.sv
// Command, queue data, primary status and fill count registers of the reader core.
// Assumes the host front end presents one decoded request per cycle on clk, and that
// the link engine, fault and interrupt logic drive their levels on the same clock.
`timescale 1ns/1ns
module command_fifo_status_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire cmd_status_pkg::host_req_t host_req,
  output logic [cmd_status_pkg::DATA_W-1:0] host_rdata,
  output cmd_status_pkg::cmd_launch_t cmd_launch,
  input wire logic cmd_finished,
  input wire logic interface_detect_done,
  input wire cmd_status_pkg::link_state_t link_state,
  input wire logic [cmd_status_pkg::FAULT_W-1:0] fault_flags_reg,
  input wire logic [cmd_status_pkg::MASK_W-1:0] interrupt_mask_reg,
  input wire logic [cmd_status_pkg::MASK_W-1:0] irq_requests,
  input wire logic [cmd_status_pkg::THR_W-1:0] queue_threshold,
  output logic irq_out,
  input wire logic core_wr_valid,
  output logic core_wr_ready,
  input wire logic [cmd_status_pkg::DATA_W-1:0] core_wr_data,
  output logic core_rd_valid,
  input wire logic core_rd_ready,
  output logic [cmd_status_pkg::DATA_W-1:0] core_rd_data
);
  logic [cmd_status_pkg::DATA_W-1:0] queue_mem [cmd_status_pkg::DEPTH];
  logic [cmd_status_pkg::PTR_W-1:0] wr_ptr_reg;
  logic [cmd_status_pkg::PTR_W-1:0] rd_ptr_reg;
  logic [cmd_status_pkg::CNT_W-1:0] count_reg;
  logic [cmd_status_pkg::CNT_W-1:0] count_next;
  logic [cmd_status_pkg::CODE_W-1:0] code_reg;
  logic detect_pending_reg;
  logic [cmd_status_pkg::DATA_W-1:0] primary_reg;
  logic irq_reg;
  logic is_full;
  logic is_empty;
  logic host_push;
  logic host_pop;
  logic core_push;
  logic core_pop;
  logic do_push;
  logic do_pop;
  logic [cmd_status_pkg::DATA_W-1:0] push_data;
  logic buf_in_ready;
  logic irq_any;
  logic hi_alert;
  logic lo_alert;
  logic [cmd_status_pkg::CNT_W-1:0] room;

  assign is_full = (count_reg == cmd_status_pkg::CNT_FULL);
  assign is_empty = (count_reg == cmd_status_pkg::CNT_ZERO);

  // Host accesses win the queue port; the link engine is held off for that cycle.
  assign host_push = host_req.wr && (host_req.addr == cmd_status_pkg::OFS_QUEUE_DATA_PORT) && !is_full;
  assign host_pop = host_req.rd && (host_req.addr == cmd_status_pkg::OFS_QUEUE_DATA_PORT) && !is_empty;
  assign core_wr_ready = !is_full && !(host_req.wr && host_req.addr == cmd_status_pkg::OFS_QUEUE_DATA_PORT);
  assign core_push = core_wr_valid && core_wr_ready;
  // The link engine drains whenever its buffer has room, so host-written bytes stay in the
  // queue only while that buffer is stalled; a host that wants to read back must stall it.
  assign core_pop = buf_in_ready && !is_empty && !host_pop;
  assign do_push = host_push || core_push;
  assign do_pop = host_pop || core_pop;
  assign push_data = host_push ? host_req.wdata : core_wr_data;

  always_ff @(posedge clk) begin
    if (do_push) begin
      queue_mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 6'h01;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 6'h01;
      end
    end
  end

  always_comb begin
    count_next = count_reg;
    if (do_push && !do_pop) begin
      count_next = count_reg + 7'h01;
    end else if (do_pop && !do_push) begin
      count_next = count_reg - 7'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= cmd_status_pkg::CNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  // Bytes handed to the buffer have left the queue; the count covers the queue alone.
  pair_buffer u_out_buffer (
    .clk(clk),
    .nrst(nrst),
    .in_valid(core_pop),
    .in_ready(buf_in_ready),
    .in_data(queue_mem[rd_ptr_reg]),
    .out_valid(core_rd_valid),
    .out_ready(core_rd_ready),
    .out_data(core_rd_data)
  );

  // A host launch in the same cycle as completion wins, so the new code is not lost.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      code_reg <= cmd_status_pkg::CODE_IDLE;
    end else if (host_req.wr && host_req.addr == cmd_status_pkg::OFS_COMMAND_START) begin
      code_reg <= host_req.wdata[cmd_status_pkg::CODE_W-1:0];
    end else if (cmd_finished) begin
      code_reg <= cmd_status_pkg::CODE_IDLE;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_launch <= '0;
    end else begin
      cmd_launch.start <= host_req.wr && host_req.addr == cmd_status_pkg::OFS_COMMAND_START;
      cmd_launch.code <= host_req.wdata[cmd_status_pkg::CODE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      detect_pending_reg <= 1'b1;
    end else begin
      detect_pending_reg <= !interface_detect_done;
    end
  end

  assign irq_any = |(irq_requests & interrupt_mask_reg);
  assign room = cmd_status_pkg::CNT_FULL - count_reg;
  assign hi_alert = room <= {1'b0, queue_threshold};
  assign lo_alert = count_reg <= {1'b0, queue_threshold};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_any;
    end
  end
  assign irq_out = irq_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      primary_reg <= cmd_status_pkg::PRIMARY_RESET;
    end else begin
      primary_reg <= {1'b0, link_state, irq_any, |fault_flags_reg, hi_alert, lo_alert};
    end
  end

  // Read data appears one edge after the read strobe.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_rdata <= cmd_status_pkg::BYTE_ZERO;
    end else if (host_req.rd) begin
      unique case (host_req.addr)
        cmd_status_pkg::OFS_COMMAND_START: host_rdata <= {detect_pending_reg, 1'b0, code_reg};
        cmd_status_pkg::OFS_QUEUE_DATA_PORT: host_rdata <= is_empty ? cmd_status_pkg::BYTE_ZERO
                                                                    : queue_mem[rd_ptr_reg];
        cmd_status_pkg::OFS_PRIMARY_STATE: host_rdata <= primary_reg;
        cmd_status_pkg::OFS_QUEUE_FILL_COUNT: host_rdata <= {1'b0, count_reg};
        default: host_rdata <= cmd_status_pkg::BYTE_ZERO;
      endcase
    end
  end

  property p_count_up;
    @(posedge clk) disable iff (!nrst)
      (do_push && !do_pop) |=> count_reg == $past(count_reg) + 7'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("fill count did not rise on write");

  property p_count_down;
    @(posedge clk) disable iff (!nrst)
      (host_pop && !do_push) |=> count_reg == $past(count_reg) - 7'h01;
  endproperty
  a_count_down: assert property (p_count_down) else $error("fill count did not fall on read");

  property p_count_bound;
    @(posedge clk) disable iff (!nrst) count_reg <= cmd_status_pkg::CNT_FULL;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("fill count beyond 64");

  property p_full_keeps;
    @(posedge clk) disable iff (!nrst)
      (is_full && host_req.wr && host_req.addr == cmd_status_pkg::OFS_QUEUE_DATA_PORT) |-> !do_push;
  endproperty
  a_full_keeps: assert property (p_full_keeps) else $error("write accepted into full queue");

  property p_fifo_order;
    @(posedge clk) disable iff (!nrst)
      (host_req.rd && host_req.addr == cmd_status_pkg::OFS_QUEUE_DATA_PORT && !is_empty)
      |=> host_rdata == $past(queue_mem[rd_ptr_reg]) && rd_ptr_reg == $past(rd_ptr_reg) + 6'h01;
  endproperty
  a_fifo_order: assert property (p_fifo_order) else $error("queue read out of order");

  property p_cmd_readback;
    @(posedge clk) disable iff (!nrst)
      (host_req.wr && host_req.addr == cmd_status_pkg::OFS_COMMAND_START)
      |=> cmd_launch.start && code_reg == $past(host_req.wdata[cmd_status_pkg::CODE_W-1:0]);
  endproperty
  a_cmd_readback: assert property (p_cmd_readback) else $error("command code not launched");

  property p_detect;
    @(posedge clk) disable iff (!nrst)
      interface_detect_done[*2] |-> !detect_pending_reg;
  endproperty
  a_detect: assert property (p_detect) else $error("detect pending after completion");

  property p_status_track;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> primary_reg[6:4] == $past(link_state) && primary_reg[cmd_status_pkg::ST_IRQ_BIT] == $past(irq_any)
               && primary_reg[cmd_status_pkg::ST_ERR_BIT] == ($past(fault_flags_reg) != '0);
  endproperty
  a_status_track: assert property (p_status_track) else $error("primary status stale");

  property p_alerts;
    @(posedge clk) disable iff (!nrst)
      1'b1 |=> primary_reg[cmd_status_pkg::ST_LO_BIT] == ($past(count_reg) <= {1'b0, $past(queue_threshold)})
               && primary_reg[cmd_status_pkg::ST_HI_BIT]
                  == ((cmd_status_pkg::CNT_FULL - $past(count_reg)) <= {1'b0, $past(queue_threshold)});
  endproperty
  a_alerts: assert property (p_alerts) else $error("fill alerts wrong");

  property p_irq_pin;
    @(posedge clk) disable iff (!nrst)
      irq_any |=> irq_out && primary_reg[cmd_status_pkg::ST_IRQ_BIT];
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("enabled request not on pin");

  property p_irq_clear;
    @(posedge clk) disable iff (!nrst) !irq_any |=> !irq_out;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt pin high with no enabled request");

  property p_empty_keeps;
    @(posedge clk) disable iff (!nrst)
      (host_req.rd && host_req.addr == cmd_status_pkg::OFS_QUEUE_DATA_PORT && is_empty && !core_push)
      |=> count_reg == cmd_status_pkg::CNT_ZERO && host_rdata == cmd_status_pkg::BYTE_ZERO;
  endproperty
  a_empty_keeps: assert property (p_empty_keeps) else $error("read of empty queue moved the count");

  property p_launch_pulse;
    @(posedge clk) disable iff (!nrst)
      (cmd_launch.start && !(host_req.wr && host_req.addr == cmd_status_pkg::OFS_COMMAND_START))
      |=> !cmd_launch.start;
  endproperty
  a_launch_pulse: assert property (p_launch_pulse) else $error("launch strobe held too long");

  // A read in the first cycle after reset is skipped, since the pending flag was forced there.
  property p_cmd_reserved;
    @(posedge clk) disable iff (!nrst)
      (host_req.rd && host_req.addr == cmd_status_pkg::OFS_COMMAND_START && $past(nrst))
      |=> host_rdata[cmd_status_pkg::CODE_W] == 1'b0
          && host_rdata[cmd_status_pkg::CMD_DETECT_BIT] == !$past(interface_detect_done, 2);
  endproperty
  a_cmd_reserved: assert property (p_cmd_reserved) else $error("command readback flags wrong");

  property p_status_reserved;
    @(posedge clk) disable iff (!nrst) primary_reg[cmd_status_pkg::DATA_W-1] == 1'b0;
  endproperty
  a_status_reserved: assert property (p_status_reserved) else $error("status reserved bit set");

  property p_link_receiving;
    @(posedge clk) disable iff (!nrst) link_state == cmd_status_pkg::LS_RX_RECEIVING;
  endproperty
  c_link_receiving: cover property (p_link_receiving);

  property p_high_alert;
    @(posedge clk) disable iff (!nrst) hi_alert && !is_full;
  endproperty
  c_high_alert: cover property (p_high_alert);

  property p_fill_to_full;
    @(posedge clk) disable iff (!nrst) is_full;
  endproperty
  c_fill_to_full: cover property (p_fill_to_full);

  property p_buffer_stall;
    @(posedge clk) disable iff (!nrst) core_rd_valid && !core_rd_ready && !buf_in_ready;
  endproperty
  c_buffer_stall: cover property (p_buffer_stall);

  property p_launch_finish;
    @(posedge clk) disable iff (!nrst) cmd_launch.start ##[1:20] cmd_finished;
  endproperty
  c_launch_finish: cover property (p_launch_finish);
endmodule

//--- rtl/cmd_status_pkg.sv
// Shared constants and carrier types for the command, queue and status register group.
// Assumes one clock domain and a host register port already decoded to a register index.
package cmd_status_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CODE_W = 6;
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam int THR_W = 6;
  localparam int MASK_W = 6;
  localparam int FAULT_W = 8;

  localparam logic [ADDR_W-1:0] OFS_COMMAND_START = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_QUEUE_DATA_PORT = 6'h02;
  localparam logic [ADDR_W-1:0] OFS_PRIMARY_STATE = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_QUEUE_FILL_COUNT = 6'h04;

  localparam int CMD_DETECT_BIT = 7;
  localparam int ST_IRQ_BIT = 3;
  localparam int ST_ERR_BIT = 2;
  localparam int ST_HI_BIT = 1;
  localparam int ST_LO_BIT = 0;

  localparam logic [CODE_W-1:0] CODE_IDLE = 6'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 7'h40;
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [DATA_W-1:0] PRIMARY_RESET = 8'h05;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    LS_IDLE = 3'h0,
    LS_SEND_FRAME_START = 3'h1,
    LS_SEND_PAYLOAD = 3'h2,
    LS_SEND_FRAME_END = 3'h3,
    LS_RX_TURNAROUND = 3'h4,
    LS_RX_GUARD_WAIT = 3'h5,
    LS_RX_LISTENING = 3'h6,
    LS_RX_RECEIVING = 3'h7
  } link_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic start;
    logic [CODE_W-1:0] code;
  } cmd_launch_t;
endpackage

//--- rtl/pair_buffer.sv
// Two-entry skid buffer with valid and ready on both sides.
// Assumes both sides run on clk; a stalled drain fills it and drops in_ready.
`timescale 1ns/1ns
module pair_buffer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [cmd_status_pkg::DATA_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [cmd_status_pkg::DATA_W-1:0] out_data
);
  logic [cmd_status_pkg::DATA_W-1:0] head_reg;
  logic [cmd_status_pkg::DATA_W-1:0] tail_reg;
  logic [1:0] used_reg;
  logic push;
  logic pop;

  assign in_ready = (used_reg != 2'h2);
  assign out_valid = (used_reg != 2'h0);
  assign out_data = head_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      used_reg <= 2'h0;
    end else if (push && !pop) begin
      used_reg <= used_reg + 2'h1;
    end else if (pop && !push) begin
      used_reg <= used_reg - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      head_reg <= cmd_status_pkg::BYTE_ZERO;
      tail_reg <= cmd_status_pkg::BYTE_ZERO;
    end else if (pop) begin
      head_reg <= (push && used_reg == 2'h1) ? in_data : tail_reg;
      if (push && used_reg == 2'h2) begin
        tail_reg <= in_data;
      end
    end else if (push) begin
      if (used_reg == 2'h0) begin
        head_reg <= in_data;
      end else begin
        tail_reg <= in_data;
      end
    end
  end

  property p_never_overfill;
    @(posedge clk) disable iff (!nrst) used_reg != 2'h3;
  endproperty
  a_never_overfill: assert property (p_never_overfill)
    else $error("pair buffer holds more than two entries");
endmodule

//--- testbench/link_engine_model.sv
// Behavioural model of the link engine on the queue side of the register group.
// Assumes the push port is sampled on the rising edge of clk and a stalled drain keeps words.
`timescale 1ns/1ns
module link_engine_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [7:0] push_n,
  input wire logic [7:0] push_base,
  input wire logic drain_en,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_data,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [7:0] rd_data,
  output logic [7:0] got_cnt,
  output logic [7:0] got_last
);
  logic [7:0] left_reg;
  logic [7:0] data_reg;
  // Between words the data lines show the inverse so a stale byte is never taken for new.
  assign wr_valid = left_reg != 8'h00;
  assign wr_data = wr_valid ? data_reg : ~data_reg;
  assign rd_ready = drain_en;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left_reg <= 8'h00;
      data_reg <= 8'h00;
      got_cnt <= 8'h00;
      got_last <= 8'h00;
    end else begin
      if (load) begin
        left_reg <= push_n;
        data_reg <= push_base;
      end else if (wr_valid && wr_ready) begin
        left_reg <= left_reg - 8'h01;
        data_reg <= data_reg + 8'h01;
      end
      if (rd_valid && rd_ready) begin
        got_cnt <= got_cnt + 8'h01;
        got_last <= rd_data;
      end
    end
  end
endmodule

//--- testbench/command_fifo_status_regs_test.sv
// Self-checking bench for the command, queue and status register group.
// Assumes host accesses per the one-cycle read latency and a link engine model on the queue side.
`timescale 1ns/1ns
module command_fifo_status_regs_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cmd_status_pkg::host_req_t host_req = '0;
  logic [7:0] host_rdata;
  cmd_status_pkg::cmd_launch_t cmd_launch;
  logic cmd_finished = 1'b0;
  logic detect_done = 1'b0;
  cmd_status_pkg::link_state_t link_state = cmd_status_pkg::LS_IDLE;
  logic [7:0] faults = 8'h01;
  logic [5:0] mask = 6'h00;
  logic [5:0] reqs = 6'h00;
  logic [5:0] thr = 6'h00;
  logic irq_out, wv, wrdy, rv, rrdy, load = 1'b0, drain = 1'b0;
  logic [7:0] wd, rdat, n = 8'h00, base = 8'h00, got_cnt, got_last;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  command_fifo_status_regs command_fifo_status_regs_i (.clk(clk), .nrst(nrst), .host_req(host_req),
    .host_rdata(host_rdata), .cmd_launch(cmd_launch), .cmd_finished(cmd_finished),
    .interface_detect_done(detect_done), .link_state(link_state), .fault_flags_reg(faults),
    .interrupt_mask_reg(mask), .irq_requests(reqs), .queue_threshold(thr), .irq_out(irq_out),
    .core_wr_valid(wv), .core_wr_ready(wrdy), .core_wr_data(wd), .core_rd_valid(rv),
    .core_rd_ready(rrdy), .core_rd_data(rdat));
  link_engine_model link_engine_model_i (.clk(clk), .nrst(nrst), .load(load), .push_n(n),
    .push_base(base), .drain_en(drain), .wr_valid(wv), .wr_ready(wrdy), .wr_data(wd),
    .rd_valid(rv), .rd_ready(rrdy), .rd_data(rdat), .got_cnt(got_cnt), .got_last(got_last));
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // A falling edge passes first so back-to-back writes never drop and raise the strobe at once.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    host_req.addr = a;
    host_req.wdata = d;
    host_req.wr = 1'b1;
    @(posedge clk);
    @(negedge clk);
    host_req.wr = 1'b0;
  endtask
  // The idle cycle first lets the one-cycle status lag settle before the read is taken.
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp, input string what);
    @(negedge clk);
    host_req.addr = a;
    host_req.rd = 1'b1;
    @(posedge clk);
    @(negedge clk);
    host_req.rd = 1'b0;
    chk(what, host_rdata, exp);
  endtask
  task automatic push(input logic [7:0] cnt, input logic [7:0] b);
    n = cnt;
    base = b;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    repeat (12) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    rdchk(6'h03, 8'h05, "status after reset");
    rdchk(6'h04, 8'h00, "count after reset");
    rdchk(6'h01, 8'h80, "command detect pending");
    rdchk(6'h05, 8'h00, "unmapped read");
    faults = 8'h00;
    detect_done = 1'b1;
    rdchk(6'h01, 8'h00, "command detect done");
    wr(6'h01, 8'hcc);
    chk("launch", {1'b0, cmd_launch}, 8'h4c);
    rdchk(6'h01, 8'h0c, "running code");
    cmd_finished = 1'b1;
    @(negedge clk);
    cmd_finished = 1'b0;
    rdchk(6'h01, 8'h00, "code after finish");
    $display("test command done");
    push(8'h02, 8'ha0);
    rdchk(6'h04, 8'h00, "buffered bytes uncounted");
    thr = 6'h04;
    for (int i = 0; i < 64; i++) begin
      wr(6'h02, 8'(i));
      if (i + 1 inside {4, 5, 59, 60}) begin
        rdchk(6'h03, {6'h00, 1'((64 - i - 1) <= 4), 1'((i + 1) <= 4)}, "alerts");
      end
    end
    wr(6'h02, 8'hff);
    rdchk(6'h04, 8'h40, "count full");
    chk("core ready when full", {7'h00, wrdy}, 8'h00);
    for (int i = 0; i < 64; i++) begin
      rdchk(6'h02, 8'(i), "queue order");
    end
    rdchk(6'h02, 8'h00, "empty read");
    rdchk(6'h04, 8'h00, "count empty");
    $display("test queue done");
    drain = 1'b1;
    repeat (6) @(negedge clk);
    chk("drained stalled bytes", got_last, 8'ha1);
    drain = 1'b0;
    push(8'h03, 8'h30);
    rdchk(6'h04, 8'h01, "count from core push");
    drain = 1'b1;
    repeat (8) @(negedge clk);
    chk("drain count", got_cnt, 8'h05);
    chk("drain last", got_last, 8'h32);
    rdchk(6'h04, 8'h00, "count after drain");
    $display("test link queue done");
    for (int k = 0; k < 8; k++) begin
      link_state = cmd_status_pkg::link_state_t'(k[2:0]);
      rdchk(6'h03, {1'b0, k[2:0], 4'h1}, "link state");
    end
    link_state = cmd_status_pkg::LS_IDLE;
    faults = 8'h80;
    rdchk(6'h03, 8'h05, "fault summary");
    faults = 8'h00;
    reqs = 6'h20;
    rdchk(6'h03, 8'h01, "masked request");
    mask = 6'h20;
    rdchk(6'h03, 8'h09, "enabled request");
    chk("interrupt pin", {7'h00, irq_out}, 8'h01);
    mask = 6'h00;
    rdchk(6'h03, 8'h01, "request masked again");
    chk("interrupt pin low", {7'h00, irq_out}, 8'h00);
    $display("test status done");
    report_and_stop();
  end
endmodule
